// ---- led_pwm_timebase_timers_test.sv ----
// Self-checking bench for the four timers joined to the six channels.
`timescale 1ns/1ps
`include "ledtb_defines.svh"

module led_pwm_timebase_timers_test
    import ledtb_pkg::*;
;
    logic             clk = 1'b0, reset = 1'b1, soft_reset = 1'b0;
    logic [1:0]       sel = 2'h1;
    logic [2:0]       src = 3'h0;
    logic [3:0][31:0] conf = '0;
    logic [3:0][3:0]  res = '0, tres;
    logic [3:0]       tup = '0, trst = '0, tpause = '0, treq, tirq;
    logic [3:0][13:0] tcnt, prev;
    logic [3:0][1:0]  tst;
    logic [5:0][1:0]  csel = '0;
    logic [5:0][9:0]  ctgt = '0;
    logic [5:0]       cen = '0, cie = '0, cup = '0, creq, cirq, done;
    logic [5:0][13:0] ccnt;
    int               fails = 0, num_checks = 0, cycles = 0, n, b, a[4], r[4], k[6];
    ////////////////////////////////////////////////////////////////////////////
    ledtb_link_if ledtb_link_if_i ();
    wire [3:0][13:0] lcnt = ledtb_link_if_i.timer_count;
    wire [3:0]       ovf = ledtb_link_if_i.timer_overflow;
    ledtb_timers ledtb_timers_i (
        .clk(clk), .reset(reset), .soft_reset(soft_reset), .pll_60mhz_clock(src[0]),
        .fast_rc_clock(src[1]), .crystal_clock(src[2]), .timer_source_clock_select(sel),
        .timer_configuration_word(conf), .counter_resolution(res),
        .timer_update_request_set(tup), .timer_counter_reset(trst), .timer_pause(tpause),
        .timer_update_request(treq), .timer_overflow_irq(tirq), .timer_count_value(tcnt),
        .timer_active_resolution(tres), .timer_state(tst), .link(ledtb_link_if_i));
    ledtb_channels ledtb_channels_i (
        .clk(clk), .reset(reset), .soft_reset(soft_reset), .channel_timer_select(csel),
        .channel_overflow_count_enable(cen), .channel_overflow_target(ctgt),
        .channel_overflow_count_irq_enable(cie), .channel_update_request_set(cup),
        .channel_update_request(creq), .channel_overflow_count_irq(cirq),
        .channel_count(ccnt), .link(ledtb_link_if_i));
    ledtb_properties ledtb_properties_i (
        .clk(clk), .reset(reset), .soft_reset(soft_reset), .timer_count(lcnt),
        .timer_overflow(ovf));
    ////////////////////////////////////////////////////////////////////////////
    always #20 clk = ~clk;
    // The selected source pulses every cycle; the others carry noise.
    always @(posedge clk) src <= 3'($urandom) | (3'h1 << (sel - 2'h1));
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic tick(input int cnt);
        repeat (cnt) @(posedge clk);
        #1;
    endtask
    // Cycles between two overflow events of one timer.
    task automatic period(input int t, output int len);
        len = 0;
        do tick(1); while (ovf[t] !== 1'b1);
        do begin tick(1); len++; end while (ovf[t] !== 1'b1);
        check("timer_irq", tirq[t], 1'b1);
    endtask
    task automatic upd(input logic [3:0] m);
        @(posedge clk);
        tup <= m;
        @(posedge clk);
        tup <= 4'h0;
        #1;
        check("update_req", treq & m, m);
    endtask
    function automatic int period_of(int pa, int pb, int pr);
        return ((pa * 256 + pb) << pr) >> 8;
    endfunction
    // Bits outside both divisor fields carry noise.
    function automatic logic [31:0] conf_of(int ca, int cb);
        return ($urandom & 32'hffc0000f) | (32'(ca) << 12) | (32'(cb) << 4);
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'haf2f));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        tick(1);
        check("state_after_reset", tst, 8'h00);
        for (int s = 1; s < 4; s++) begin
            @(posedge clk);
            sel <= 2'(s);
            for (int t = 0; t < 4; t++) begin
                a[t] = 1 + $urandom % 4;
                r[t] = 1 + $urandom % 3;
                conf[t] <= conf_of(a[t], 0);
                res[t] <= 4'(r[t]);
            end
            upd(4'hf);
            for (int t = 0; t < 4; t++) begin
                period(t, n);
                check("int_period", n, period_of(a[t], 0, r[t]));
                check("active_res", tres[t], r[t]);
            end
            check("update_cleared", treq, 4'h0);
        end
        @(posedge clk);
        a[0] = 1 + $urandom % 3;
        b = 1 + $urandom % 255;
        conf[0] <= conf_of(a[0], b);
        conf[1] <= conf_of(a[0], b);
        res[0] <= 4'h8;
        res[1] <= 4'h1;
        upd(4'h3);
        period(0, n);
        check("frac_period", n, period_of(a[0], b, 8));
        for (int i = 0; i < 8; i++) begin
            period(1, n);
            check("frac_spread", 32'((n - period_of(a[0], b, 1)) inside {0, 1}), 1);
        end
        @(posedge clk);
        conf[0] <= conf_of(a[0] + 1, 0);
        period(0, n);
        check("no_update_period", n, period_of(a[0], b, 8));
        @(posedge clk);
        sel <= 2'h0;
        tick(2);
        n = tcnt[0];
        tick(5);
        check("no_source_count", tcnt[0], n);
        @(posedge clk);
        sel <= 2'h3;
        @(posedge clk);
        tpause <= 4'h4;
        tick(2);
        n = tcnt[2];
        tick(5);
        check("paused_count", tcnt[2], n);
        check("paused_state", tst[2], 2'h2);
        @(posedge clk);
        tpause <= 4'h0;
        trst <= 4'h4;
        tick(2);
        check("cleared_count", tcnt[2], 14'h0000);
        @(posedge clk);
        trst <= 4'h0;
        soft_reset <= 1'b1;
        res <= '0;
        @(posedge clk);
        soft_reset <= 1'b0;
        tick(1);
        check("soft_reset_counts", 32'(|lcnt), 0);
        @(posedge clk);
        for (int c = 0; c < 6; c++) begin
            csel[c] <= 2'($urandom);
            ctgt[c] <= 10'($urandom % 4);
            k[c] = 0;
        end
        cen <= 6'h3f;
        cie <= 6'h3f;
        cup <= 6'h3f;
        @(posedge clk);
        cup <= 6'h00;
        #1;
        check("chan_update_req", creq, 6'h3f);
        tick(1);
        check("chan_update_clear", creq, 6'h00);
        @(posedge clk);
        res <= {4'h2, 4'h3, 4'h1, 4'h2};
        done = 6'h00;
        while (done !== 6'h3f) begin
            prev = lcnt;
            tick(1);
            for (int c = 0; c < 6; c++) begin
                check("chan_follow", ccnt[c], prev[csel[c]]);
                if (!done[c] && cirq[c] === 1'b1) begin
                    check("chan_irq_after", k[c], ctgt[c] + 1);
                    done[c] = 1'b1;
                end else if (ovf[csel[c]] === 1'b1) begin
                    k[c]++;
                end
            end
        end
        @(posedge clk);
        tpause <= 4'hf;
        tick(3);
        for (int c = 0; c < 6; c++) check("chan_count", ccnt[c], lcnt[csel[c]]);
        conclude();
    end
endmodule // led_pwm_timebase_timers_test

// ---- ledtb_channels.sv ----
// Six channels that follow a chosen timer and count its overflows.
`timescale 1ns/1ps
`include "ledtb_defines.svh"

module ledtb_channels
    import ledtb_pkg::*;
(
    input  wire logic                                                clk,
    input  wire logic                                                reset,
    input  wire logic                                                soft_reset,
    input  wire logic [`LEDTB_NUM_CHANNELS-1:0][`LEDTB_TSEL_W-1:0]   channel_timer_select,
    input  wire logic [`LEDTB_NUM_CHANNELS-1:0]                      channel_overflow_count_enable,
    input  wire logic [`LEDTB_NUM_CHANNELS-1:0][`LEDTB_OVF_TARGET_W-1:0] channel_overflow_target,
    input  wire logic [`LEDTB_NUM_CHANNELS-1:0]                      channel_overflow_count_irq_enable,
    input  wire logic [`LEDTB_NUM_CHANNELS-1:0]                      channel_update_request_set,
    output logic      [`LEDTB_NUM_CHANNELS-1:0]                      channel_update_request,
    output logic      [`LEDTB_NUM_CHANNELS-1:0]                      channel_overflow_count_irq,
    output logic      [`LEDTB_NUM_CHANNELS-1:0][`LEDTB_CNT_W-1:0]    channel_count,
    ledtb_link_if.channel_end                                        link
);

    logic rst;

    assign rst = reset | soft_reset;

    ////////////////////////////////////////////////////////////////////////////
    // One channel per loop pass.

    for (genvar c = 0; c < `LEDTB_NUM_CHANNELS; c++) begin : g_chan
        ledtb_tsel_t       sel_r;
        logic              en_r;
        logic              upd_r;
        ledtb_ovf_target_t ovf_cnt_r;
        ledtb_cnt_t        count_r;
        logic              irq_r;
        logic              sel_ovf;
        logic              hit;

        // Selection and enable take effect only through the update request.
        always_ff @(posedge clk) begin
            if (rst) begin
                sel_r <= '0;
                en_r  <= 1'b0;
            end else if (upd_r) begin
                sel_r <= channel_timer_select[c];
                en_r  <= channel_overflow_count_enable[c];
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                upd_r <= 1'b0;
            end else begin
                upd_r <= channel_update_request_set[c];
            end
        end

        assign sel_ovf = link.timer_overflow[sel_r];
        assign hit     = en_r && sel_ovf && (ovf_cnt_r == channel_overflow_target[c]);

        always_ff @(posedge clk) begin
            if (rst || !en_r) begin
                ovf_cnt_r <= `LEDTB_OVF_TARGET_RST;
            end else if (hit) begin
                ovf_cnt_r <= `LEDTB_OVF_TARGET_RST;
            end else if (sel_ovf) begin
                ovf_cnt_r <= ovf_cnt_r + ledtb_ovf_target_t'(1);
            end
        end

        always_ff @(posedge clk) begin
            if (rst) begin
                irq_r   <= 1'b0;
                count_r <= `LEDTB_CNT_RST;
            end else begin
                irq_r   <= hit && channel_overflow_count_irq_enable[c];
                count_r <= link.timer_count[sel_r];
            end
        end

        assign channel_update_request[c]     = upd_r;
        assign channel_overflow_count_irq[c] = irq_r;
        assign channel_count[c]              = count_r;
    end

endmodule // ledtb_channels

// ---- ledtb_defines.svh ----
// Constants for the LED PWM timebase timers and their channel end.
`ifndef LEDTB_DEFINES_SVH
`define LEDTB_DEFINES_SVH

`define LEDTB_NUM_TIMERS      4
`define LEDTB_NUM_CHANNELS    6
`define LEDTB_CNT_W           14
`define LEDTB_RES_W           4
`define LEDTB_RES_MAX         4'he
`define LEDTB_CONF_W          32
`define LEDTB_DIV_A_MSB       21
`define LEDTB_DIV_A_LSB       12
`define LEDTB_DIV_A_W         10
`define LEDTB_DIV_B_MSB       11
`define LEDTB_DIV_B_LSB       4
`define LEDTB_DIV_B_W         8
`define LEDTB_SRC_W           2
`define LEDTB_SRC_PLL60       2'h1
`define LEDTB_SRC_FAST_RC     2'h2
`define LEDTB_SRC_CRYSTAL     2'h3
`define LEDTB_TSEL_W          2
`define LEDTB_OVF_TARGET_W    10
`define LEDTB_CNT_RST         14'h0000
`define LEDTB_RES_RST         4'h0
`define LEDTB_DIV_A_RST       10'h000
`define LEDTB_DIV_B_RST       8'h00
`define LEDTB_OVF_TARGET_RST  10'h000

`endif

// ---- ledtb_link_if.sv ----
// Link carrying live timer counts and overflow events to the channels.
`timescale 1ns/1ps
`include "ledtb_defines.svh"

interface ledtb_link_if;
    logic [`LEDTB_NUM_TIMERS-1:0][`LEDTB_CNT_W-1:0] timer_count;
    logic [`LEDTB_NUM_TIMERS-1:0]                   timer_overflow;

    modport timer_end (
        output timer_count,
        output timer_overflow
    );
    modport channel_end (
        input  timer_count,
        input  timer_overflow
    );
endinterface

// ---- ledtb_pkg.sv ----
// Types shared by both ends of the LED PWM timebase.
`include "ledtb_defines.svh"

package ledtb_pkg;
    typedef logic [`LEDTB_CNT_W-1:0]        ledtb_cnt_t;
    typedef logic [`LEDTB_RES_W-1:0]        ledtb_res_t;
    typedef logic [`LEDTB_DIV_A_W-1:0]      ledtb_div_a_t;
    typedef logic [`LEDTB_DIV_B_W-1:0]      ledtb_div_b_t;
    typedef logic [`LEDTB_DIV_A_W:0]        ledtb_period_t;
    typedef logic [`LEDTB_CONF_W-1:0]       ledtb_conf_t;
    typedef logic [`LEDTB_TSEL_W-1:0]       ledtb_tsel_t;
    typedef logic [`LEDTB_OVF_TARGET_W-1:0] ledtb_ovf_target_t;
    typedef enum logic [1:0] {
        LEDTB_TIMER_IDLE,
        LEDTB_TIMER_RUN,
        LEDTB_TIMER_PAUSED
    } ledtb_timer_state_t;
endpackage

// ---- ledtb_properties.sv ----
// Concurrent checks on the link that joins the timers to the channels.
`timescale 1ns/1ps
`include "ledtb_defines.svh"

module ledtb_properties
    import ledtb_pkg::*;
(
    input wire logic                                           clk,
    input wire logic                                           reset,
    input wire logic                                           soft_reset,
    input wire logic [`LEDTB_NUM_TIMERS-1:0][`LEDTB_CNT_W-1:0] timer_count,
    input wire logic [`LEDTB_NUM_TIMERS-1:0]                   timer_overflow
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset || soft_reset);
    ////////////////////////////////////////////////////////////////////////////
    for (genvar i = 0; i < `LEDTB_NUM_TIMERS; i++) begin : g_tmr
        sequence s_up;
            timer_count[i] > $past(timer_count[i]);
        endsequence
        sequence s_down;
            timer_count[i] < $past(timer_count[i]);
        endsequence
        // The count has just left a value of two to a power, minus one.
        sequence s_from_max;
            $past(timer_count[i]) != 14'h0000 &&
                ($past(timer_count[i]) & ($past(timer_count[i]) + 14'h0001)) == 14'h0000;
        endsequence
        AST_CNT_STEP_UP: assert property (
            s_up |-> timer_count[i] == $past(timer_count[i]) + 14'h0001)
            else $error("count rose by more than one");
        AST_CNT_STEP_DOWN: assert property (
            s_down |-> timer_count[i] == 14'h0000)
            else $error("count fell to a nonzero value");
        AST_OVF_ZERO: assert property (
            timer_overflow[i] |-> timer_count[i] == 14'h0000)
            else $error("overflow event without a restart from zero");
        AST_OVF_FROM_MAX: assert property (
            timer_overflow[i] |-> s_from_max)
            else $error("overflow event not preceded by the top count");
        AST_OVF_PULSE: assert property (
            timer_overflow[i] |=> !timer_overflow[i])
            else $error("overflow event longer than one cycle");
        AST_RESTART_LOW: assert property (
            timer_overflow[i] |=> timer_count[i] <= 14'h0001)
            else $error("count jumped after restart");
        AST_RESET_CLEAR: assert property (
            $fell(reset) |-> timer_count[i] == 14'h0000 && !timer_overflow[i])
            else $error("link not cleared by reset");
        AST_SOFT_CLEAR: assert property (
            $fell(soft_reset) |-> timer_count[i] == 14'h0000 && !timer_overflow[i])
            else $error("link not cleared by soft reset");
    end
endmodule // ledtb_properties

// ---- ledtb_timers.sv ----
// Four timebase timers with fractional dividers and overflow counters.
//
// Summary of operation
// - Four identical, independently configured timers.
// - Common two-bit select picks source clock.
// - Tick rate is source over A+B/256.
// - A in bits 21:12, B in 11:4.
// - B zero: one tick per A pulses.
// - B of 256 ticks last A+1, spread evenly.
// - New divisor applies at overflow after update request.
// - 14-bit counter wraps after two-power resolution minus one.
// - Count readable, resettable and pausable by software.
// - Every overflow raises the timer overflow event.
// - Channel raises interrupt after target plus one overflows.
// - Software order: select, enable, target, irq, resolution.
// - New resolution applies at overflow after update request.
// - Channel enable applies only after channel update request.
// - Each channel follows its selected timer's live count.
// - Registers on bus clock; soft reset clears block.
`timescale 1ns/1ps
`include "ledtb_defines.svh"

module ledtb_timers
    import ledtb_pkg::*;
(
    input  wire logic                                       clk,
    input  wire logic                                       reset,
    input  wire logic                                       soft_reset,
    input  wire logic                                       pll_60mhz_clock,
    input  wire logic                                       fast_rc_clock,
    input  wire logic                                       crystal_clock,
    input  wire logic [`LEDTB_SRC_W-1:0]                    timer_source_clock_select,
    input  wire logic [`LEDTB_NUM_TIMERS-1:0][`LEDTB_CONF_W-1:0] timer_configuration_word,
    input  wire logic [`LEDTB_NUM_TIMERS-1:0][`LEDTB_RES_W-1:0]  counter_resolution,
    input  wire logic [`LEDTB_NUM_TIMERS-1:0]               timer_update_request_set,
    input  wire logic [`LEDTB_NUM_TIMERS-1:0]               timer_counter_reset,
    input  wire logic [`LEDTB_NUM_TIMERS-1:0]               timer_pause,
    output logic      [`LEDTB_NUM_TIMERS-1:0]               timer_update_request,
    output logic      [`LEDTB_NUM_TIMERS-1:0]               timer_overflow_irq,
    output logic      [`LEDTB_NUM_TIMERS-1:0][`LEDTB_CNT_W-1:0] timer_count_value,
    output logic      [`LEDTB_NUM_TIMERS-1:0][`LEDTB_RES_W-1:0] timer_active_resolution,
    output logic      [`LEDTB_NUM_TIMERS-1:0][1:0]          timer_state,
    ledtb_link_if.timer_end                                 link
);

    ////////////////////////////////////////////////////////////////////////////
    // Common source selection and reset.

    logic rst;
    logic pick_pll;
    logic pick_fast_rc;
    logic pick_crystal;
    logic src_pulse;

    // The soft reset acts exactly like the pin reset, on every register of the block.
    assign rst = reset | soft_reset;

    // Each source input is a one-cycle qualifier on clk, so a timer ticks at most once
    // per clk cycle; a source faster than clk must be thinned out before it arrives.
    // Select value zero names no source, and every timer then stands still.
    assign pick_pll     = (timer_source_clock_select == `LEDTB_SRC_PLL60);
    assign pick_fast_rc = (timer_source_clock_select == `LEDTB_SRC_FAST_RC);
    assign pick_crystal = (timer_source_clock_select == `LEDTB_SRC_CRYSTAL);
    assign src_pulse    = (pick_pll && pll_60mhz_clock) ||
                          (pick_fast_rc && fast_rc_clock) ||
                          (pick_crystal && crystal_clock);

    ////////////////////////////////////////////////////////////////////////////
    // One timer per loop pass.

    for (genvar t = 0; t < `LEDTB_NUM_TIMERS; t++) begin : g_timer
        ledtb_div_a_t       act_a_r;
        ledtb_div_b_t       act_b_r;
        ledtb_res_t         act_res_r;
        ledtb_period_t      div_cnt_r;
        ledtb_div_b_t       acc_r;
        ledtb_cnt_t         cnt_r;
        logic               upd_r;
        logic               ovf_r;
        ledtb_timer_state_t state_r;
        ledtb_timer_state_t state_nxt;

        ledtb_div_a_t  cfg_a;
        ledtb_div_b_t  cfg_b;
        ledtb_div_a_t  a_eff;
        logic [`LEDTB_DIV_B_W:0] acc_sum;
        logic          carry;
        ledtb_period_t period;
        ledtb_period_t div_cnt_inc;
        ledtb_res_t    res_c;
        ledtb_cnt_t    cnt_max;
        logic          idle;
        logic          run;
        logic          tick;
        logic          ovf;
        logic          apply;

        ////////////////////////////////////////////////////////////////////////
        // Divider and counter datapath.

        assign cfg_a = timer_configuration_word[t][`LEDTB_DIV_A_MSB:`LEDTB_DIV_A_LSB];
        assign cfg_b = timer_configuration_word[t][`LEDTB_DIV_B_MSB:`LEDTB_DIV_B_LSB];

        // A divisor of zero cannot count, so it behaves as one.
        assign a_eff       = (act_a_r == '0) ? ledtb_div_a_t'(1) : act_a_r;
        // The carry out of the phase accumulator marks the long ticks; B carries
        // per 256 ticks, evenly spaced by construction.
        assign acc_sum     = {1'b0, acc_r} + {1'b0, act_b_r};
        assign carry       = acc_sum[`LEDTB_DIV_B_W];
        assign period      = {1'b0, a_eff} + ledtb_period_t'(carry);
        assign div_cnt_inc = div_cnt_r + ledtb_period_t'(1);

        // Resolutions above the counter width clamp to the full width.
        assign res_c   = (act_res_r > `LEDTB_RES_MAX) ? `LEDTB_RES_MAX : act_res_r;
        assign cnt_max = ledtb_cnt_t'(({1'b0, {`LEDTB_CNT_W{1'b0}}} | (15'h0001 << res_c))
                                      - 15'h0001);

        // A timer with zero active resolution is idle; writing a resolution starts it.
        assign idle = (act_res_r == '0);
        assign run  = !idle && !timer_pause[t];
        assign tick = run && src_pulse && (div_cnt_inc == period);
        assign ovf  = tick && (cnt_r == cnt_max);

        // Both fields move in the same cycle, so no mixed setting is ever used.
        assign apply = idle || (ovf && upd_r);

        ////////////////////////////////////////////////////////////////////////
        // Registers of this timer.

        // While idle the active set follows the inputs, so a timer starts with
        // whatever divisor stands beside the resolution that wakes it.
        always_ff @(posedge clk) begin
            if (rst) begin
                act_a_r   <= `LEDTB_DIV_A_RST;
                act_b_r   <= `LEDTB_DIV_B_RST;
                act_res_r <= `LEDTB_RES_RST;
            end else if (apply) begin
                act_a_r   <= cfg_a;
                act_b_r   <= cfg_b;
                act_res_r <= counter_resolution[t];
            end
        end

        // A request raised in the applying cycle stays pending.
        always_ff @(posedge clk) begin
            if (rst) begin
                upd_r <= 1'b0;
            end else begin
                upd_r <= timer_update_request_set[t] | (upd_r & ~apply);
            end
        end

        // A counter reset or an idle timer restarts the divider and its phase, so
        // the first tick after a restart is a whole one.
        always_ff @(posedge clk) begin
            if (rst || timer_counter_reset[t] || idle) begin
                div_cnt_r <= '0;
                acc_r     <= `LEDTB_DIV_B_RST;
            end else if (tick) begin
                div_cnt_r <= '0;
                acc_r     <= acc_sum[`LEDTB_DIV_B_W-1:0];
            end else if (run && src_pulse) begin
                div_cnt_r <= div_cnt_inc;
            end
        end

        // The wrap happens on the tick that would pass the top count.
        always_ff @(posedge clk) begin
            if (rst || timer_counter_reset[t] || idle) begin
                cnt_r <= `LEDTB_CNT_RST;
            end else if (ovf) begin
                cnt_r <= `LEDTB_CNT_RST;
            end else if (tick) begin
                cnt_r <= cnt_r + ledtb_cnt_t'(1);
            end
        end

        // The overflow event is registered, so it stands for the one cycle after the wrap.
        always_ff @(posedge clk) begin
            if (rst) begin
                ovf_r <= 1'b0;
            end else begin
                ovf_r <= ovf;
            end
        end

        always_comb begin
            state_nxt = LEDTB_TIMER_RUN;
            if (idle) begin
                state_nxt = LEDTB_TIMER_IDLE;
            end else if (timer_pause[t]) begin
                state_nxt = LEDTB_TIMER_PAUSED;
            end
        end

        // The reported state is registered like the other data outputs.
        always_ff @(posedge clk) begin
            if (rst) begin
                state_r <= LEDTB_TIMER_IDLE;
            end else begin
                state_r <= state_nxt;
            end
        end

        assign timer_update_request[t]    = upd_r;
        assign timer_overflow_irq[t]      = ovf_r;
        assign timer_count_value[t]       = cnt_r;
        assign timer_active_resolution[t] = act_res_r;
        assign timer_state[t]             = state_r;
        assign link.timer_count[t]        = cnt_r;
        assign link.timer_overflow[t]     = ovf_r;
    end

endmodule // ledtb_timers
